// >>> dbe_cfg.svh
// Register offsets, field positions and reset values of the debug event block
`ifndef DBE_CFG_SVH
`define DBE_CFG_SVH

// Byte offsets of the registers on the bus
`define DBE_OFS_CTL0      8'h00
`define DBE_OFS_CTL1      8'h04
`define DBE_OFS_STATUS    8'h08
`define DBE_OFS_ADDR1     8'h0C
`define DBE_OFS_ADDR2     8'h10
`define DBE_OFS_VAL1      8'h14
`define DBE_OFS_VAL2      8'h18
`define DBE_OFS_SAVE      8'h1C

// Word transfers only
`define DBE_HSIZE_WORD    3'h2

// debug_control_0 fields
`define DBE_C0_INTMODE    0
`define DBE_C0_FREEZE     1
`define DBE_C0_RST        2'h0

// debug_control_1 fields
`define DBE_C1_R1EN       0
`define DBE_C1_W1EN       1
`define DBE_C1_R2EN       2
`define DBE_C1_W2EN       3
`define DBE_C1_RANGE      4
`define DBE_C1_EXCL       5
`define DBE_C1_BE1_LO     8
`define DBE_C1_BE2_LO     12
`define DBE_C1_M1_LO      16
`define DBE_C1_M2_LO      18
`define DBE_C1_RST        20'h00000

// debug_status_reg fields
`define DBE_ST_RH1        0
`define DBE_ST_WH1        1
`define DBE_ST_RH2        2
`define DBE_ST_WH2        3
`define DBE_ST_IMPR       4
`define DBE_ST_DONE       5
`define DBE_ST_BRANCH     6
`define DBE_ST_EXC        7
`define DBE_ST_TRAP       8
`define DBE_ST_UNC        9
`define DBE_ST_IADDR      10
`define DBE_ST_CAUSE_LO   12
`define DBE_ST_RST        11'h000

`endif

// >>> dbe_events.sv
// Debug event logic: value compare, imprecise events and timer freeze
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "dbe_cfg.svh"

module dbe_events (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // AHB-Lite slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  // Data access from the load/store unit
  input  wire logic              access_valid_i,
  input  wire logic              access_write_i,
  input  wire logic              access_split_i,
  input  wire logic [31:0]       access_addr_i,
  input  wire logic [31:0]       access_data_i,
  input  wire logic [31:0]       next_pc_i,
  // Other debug events and processor state
  input  wire logic              instr_complete_event_i,
  input  wire logic              branch_taken_event_i,
  input  wire logic              exception_taken_event_i,
  input  wire logic              trap_event_i,
  input  wire logic              unconditional_event_i,
  input  wire logic              instr_addr_compare_i,
  input  wire logic              range_toggle_en_i,
  input  wire logic              debug_irq_enable_i,
  input  wire logic [1:0]        last_reset_cause_i,
  // Event outputs
  output logic                   debug_irq_o,
  output logic                   abort_second_o,
  output logic                   value_event_o,
  output logic                   timers_frozen_o
);
  import dbe_pkg::*;

  dbe_state_t s;
  dbe_state_t next_s;

  // Byte-wise value match of one comparator
  function automatic logic value_match(input logic [3:0] be, input dbe_mode_t mode,
                                       input logic [31:0] cmp, input logic [31:0] data);
    logic [3:0] eq;
    logic       res;
    eq  = 4'h0;
    res = 1'b0;
    for (int i = 0; i < 4; i++) begin
      eq[i] = be[i] && (cmp[31-8*i -: 8] == data[31-8*i -: 8]);
    end
    case (mode)
      DBE_MODE_AND:   res = (be != 4'h0) && ((eq | ~be) == 4'hF);
      DBE_MODE_OR:    res = (eq != 4'h0);
      DBE_MODE_ANDOR: res = (eq[0] && eq[1]) || (eq[2] && eq[3]);
      default:        res = 1'b0; // Undefined mode never matches
    endcase
    return res;
  endfunction

  // Decoded control fields
  logic [3:0]  be1;
  logic [3:0]  be2;
  dbe_mode_t   mode1;
  dbe_mode_t   mode2;
  logic        vc_en1;
  logic        vc_en2;
  logic        in_span;
  logic        range_hit;
  logic        hit1;
  logic        hit2;
  logic        chk1;
  logic        chk2;
  logic        vm1;
  logic        vm2;
  logic        ev1;
  logic        ev2;
  logic        vc_event;
  logic        any_event;
  logic        impr_set;
  logic        irq_cond;
  logic        addr_phase;
  logic [10:0] set_bits;
  logic [10:0] clr_bits;

  // Address and value comparison
  always_comb begin
    be1       = s.ctl1[`DBE_C1_BE1_LO +: 4];
    be2       = s.ctl1[`DBE_C1_BE2_LO +: 4];
    mode1     = dbe_mode_t'(s.ctl1[`DBE_C1_M1_LO +: 2]);
    mode2     = dbe_mode_t'(s.ctl1[`DBE_C1_M2_LO +: 2]);
    vc_en1    = (be1 != 4'h0);
    vc_en2    = (be2 != 4'h0);
    in_span   = (access_addr_i >= s.addr1) && (access_addr_i < s.addr2);
    range_hit = s.ctl1[`DBE_C1_EXCL] ? !in_span : in_span;
    hit1      = s.ctl1[`DBE_C1_RANGE] ? range_hit : (access_addr_i == s.addr1);
    hit2      = s.ctl1[`DBE_C1_RANGE] ? range_hit : (access_addr_i == s.addr2);
    chk1      = access_write_i ? s.ctl1[`DBE_C1_W1EN] : s.ctl1[`DBE_C1_R1EN];
    chk2      = access_write_i ? s.ctl1[`DBE_C1_W2EN] : s.ctl1[`DBE_C1_R2EN];
    vm1       = value_match(be1, mode1, s.val1, access_data_i);
    vm2       = value_match(be2, mode2, s.val2, access_data_i);
    // Address hit alone raises an event only while value compare is off
    ev1       = access_valid_i && chk1 && hit1 && (!vc_en1 || vm1);
    ev2       = access_valid_i && chk2 && hit2 && (!vc_en2 || vm2);
    vc_event  = (ev1 && vc_en1) || (ev2 && vc_en2);
    any_event = ev1 || ev2 || instr_complete_event_i || branch_taken_event_i ||
                exception_taken_event_i || trap_event_i || unconditional_event_i ||
                instr_addr_compare_i;
    // Qualifying events while interrupts are masked
    impr_set  = !debug_irq_enable_i && (
                ((instr_complete_event_i || branch_taken_event_i) && !s.int_mode) ||
                (instr_addr_compare_i && !(range_toggle_en_i && s.int_mode)) ||
                exception_taken_event_i || trap_event_i || unconditional_event_i ||
                ev1 || ev2);
    irq_cond  = debug_irq_enable_i && s.int_mode;
  end

  // Status set and clear vectors
  always_comb begin
    set_bits                = 11'h000;
    set_bits[`DBE_ST_RH1]   = ev1 && !access_write_i;
    set_bits[`DBE_ST_WH1]   = ev1 && access_write_i;
    set_bits[`DBE_ST_RH2]   = ev2 && !access_write_i;
    set_bits[`DBE_ST_WH2]   = ev2 && access_write_i;
    set_bits[`DBE_ST_IMPR]   = impr_set;
    set_bits[`DBE_ST_DONE]   = instr_complete_event_i;
    set_bits[`DBE_ST_BRANCH] = branch_taken_event_i;
    set_bits[`DBE_ST_EXC]    = exception_taken_event_i;
    set_bits[`DBE_ST_TRAP]   = trap_event_i;
    set_bits[`DBE_ST_UNC]    = unconditional_event_i;
    set_bits[`DBE_ST_IADDR]  = instr_addr_compare_i;
    clr_bits = (s.wr_pend && s.wr_addr == `DBE_OFS_STATUS) ? hwdata_i[10:0] : 11'h000;
  end

  // Next state: bus slave, status, interrupt and freeze
  always_comb begin
    next_s        = s;
    next_s.hready = 1'b1;
    addr_phase    = hsel_i && htrans_i[1] && hready_i && (hsize_i == `DBE_HSIZE_WORD);
    // Strap of the reset cause caught once after release
    if (!s.cause_caught) begin
      next_s.reset_cause  = last_reset_cause_i;
      next_s.cause_caught = 1'b1;
    end
    // Data phase of a write
    if (s.wr_pend) begin
      case (s.wr_addr)
        `DBE_OFS_CTL0: begin
          next_s.int_mode  = hwdata_i[`DBE_C0_INTMODE];
          next_s.freeze_en = hwdata_i[`DBE_C0_FREEZE];
        end
        `DBE_OFS_CTL1:  next_s.ctl1  = hwdata_i[19:0];
        `DBE_OFS_ADDR1: next_s.addr1 = hwdata_i;
        `DBE_OFS_ADDR2: next_s.addr2 = hwdata_i;
        `DBE_OFS_VAL1:  next_s.val1  = hwdata_i;
        `DBE_OFS_VAL2:  next_s.val2  = hwdata_i;
        default: ;
      endcase
    end
    next_s.wr_pend = addr_phase && hwrite_i;
    next_s.wr_addr = haddr_i[7:0];
    // Address phase of a read loads the read data flop
    if (addr_phase && !hwrite_i) begin
      case (haddr_i[7:0])
        `DBE_OFS_CTL0:   next_s.rdata = {30'h0, s.freeze_en, s.int_mode};
        `DBE_OFS_CTL1:   next_s.rdata = {12'h000, s.ctl1};
        `DBE_OFS_STATUS: next_s.rdata = {18'h00000, s.reset_cause, 1'b0, s.status};
        `DBE_OFS_ADDR1:  next_s.rdata = s.addr1;
        `DBE_OFS_ADDR2:  next_s.rdata = s.addr2;
        `DBE_OFS_VAL1:   next_s.rdata = s.val1;
        `DBE_OFS_VAL2:   next_s.rdata = s.val2;
        `DBE_OFS_SAVE:   next_s.rdata = s.save_restore;
        default:         next_s.rdata = 32'h00000000;
      endcase
    end
    // Write-one-to-clear status, a set in the same cycle wins
    next_s.status = (s.status & ~clr_bits) | set_bits;
    // Value event and interrupt, signalled in the cycle after the access
    next_s.vc_evt     = vc_event;
    next_s.irq_cond_q = irq_cond;
    next_s.irq        = (vc_event && irq_cond) ||
                        (irq_cond && !s.irq_cond_q && s.status[`DBE_ST_IMPR]);
    next_s.abort      = vc_event && irq_cond && access_split_i;
    if ((vc_event && irq_cond) || (irq_cond && !s.irq_cond_q && s.status[`DBE_ST_IMPR])) begin
      next_s.save_restore = next_pc_i;
    end
    // Timer freeze, resumed only on an all-clear status
    if (s.freeze_en && any_event) begin
      next_s.frozen = 1'b1;
    end else if (s.status == 11'h000) begin
      next_s.frozen = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.ctl1   <= `DBE_C1_RST;
      s.status <= `DBE_ST_RST;
      s.hready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign hreadyout_o     = s.hready;
  assign hresp_o         = 1'b0 & s.hready;
  assign hrdata_o        = s.rdata;
  assign debug_irq_o     = s.irq;
  assign abort_second_o  = s.abort;
  assign value_event_o   = s.vc_evt;
  assign timers_frozen_o = s.frozen;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Value event only follows a completed data access
  AST_VC_AFTER_ACCESS: assert property (
    value_event_o |-> $past(access_valid_i) && $past(hit1 || hit2))
    else $error("value event without a matching access");

  // Zero byte enables never give a value event from comparator 1
  AST_BE_ZERO_OFF: assert property (
    (access_valid_i && be1 == 4'h0 && !ev2) |=> !value_event_o)
    else $error("value event with byte enables cleared");

  // Full-word AND match on comparator 1 raises a value event
  AST_AND_FULL_MATCH: assert property (
    (access_valid_i && chk1 && hit1 && be1 == 4'hF && mode1 == DBE_MODE_AND &&
     access_data_i == s.val1) |=> value_event_o)
    else $error("AND mode full match missed");

  // Mismatch leaves comparator 1 status bits alone
  AST_MISMATCH_KEEPS: assert property (
    (access_valid_i && hit1 && vc_en1 && !vm1 && !s.wr_pend && !ev2)
    |=> $stable(s.status[`DBE_ST_WH1:`DBE_ST_RH1]))
    else $error("status changed on value mismatch");

  // A write hit on comparator 1 records the write status bit, value event only if enabled
  AST_WRITE_STATUS: assert property (
    (ev1 && access_write_i && !ev2) |=>
    (s.status[`DBE_ST_WH1] && (value_event_o == $past(vc_en1))))
    else $error("write hit status not recorded");

  // A masked exception event sets the imprecise flag
  AST_IMPR_SET: assert property (
    (!debug_irq_enable_i && exception_taken_event_i) |=> s.status[`DBE_ST_IMPR])
    else $error("imprecise flag not set");

  // Instruction complete alone in internal mode gives no imprecise flag
  AST_DONE_NO_IMPR: assert property (
    (s.int_mode && !debug_irq_enable_i && !s.status[`DBE_ST_IMPR] && instr_complete_event_i &&
     !branch_taken_event_i && !exception_taken_event_i && !trap_event_i &&
     !unconditional_event_i && !instr_addr_compare_i && !ev1 && !ev2)
    |=> !s.status[`DBE_ST_IMPR])
    else $error("imprecise flag set in internal mode");

  // Enabling with the flag pending interrupts at once with the next address
  AST_IMPR_IRQ: assert property (
    (irq_cond && !s.irq_cond_q && s.status[`DBE_ST_IMPR])
    |=> debug_irq_o && s.save_restore == $past(next_pc_i))
    else $error("pending imprecise event did not interrupt");

  // The second half is abandoned only together with the interrupt
  AST_SPLIT_ABORT: assert property (
    abort_second_o |-> debug_irq_o && value_event_o)
    else $error("second access aborted without interrupt");

  // Any event with the freeze bit set freezes the timers
  AST_FREEZE: assert property (
    (s.freeze_en && any_event) |=> timers_frozen_o)
    else $error("timers not frozen on event");

  // Frozen timers stay frozen while any status bit is set
  AST_STAY_FROZEN: assert property (
    (timers_frozen_o && s.status != 11'h000) |=> timers_frozen_o)
    else $error("timers resumed with status pending");

endmodule // dbe_events

// >>> dbe_pkg.sv
// Types shared by the debug event block
package dbe_pkg;

  // Compare-mode encodings of a value comparator
  typedef enum logic [1:0] {
    DBE_MODE_UNDEF,
    DBE_MODE_AND,
    DBE_MODE_OR,
    DBE_MODE_ANDOR
  } dbe_mode_t;

  // Complete register state of the block
  typedef struct packed {
    logic        int_mode;
    logic        freeze_en;
    logic [19:0] ctl1;
    logic [31:0] addr1;
    logic [31:0] addr2;
    logic [31:0] val1;
    logic [31:0] val2;
    logic [10:0] status;
    logic [1:0]  reset_cause;
    logic        cause_caught;
    logic [31:0] save_restore;
    logic        irq_cond_q;
    logic        irq;
    logic        abort;
    logic        vc_evt;
    logic        frozen;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        hready;
  } dbe_state_t;

endpackage

// >>> tb_top.sv
// Self-checking testbench of the debug event block
`timescale 1ns/100ps
`include "dbe_cfg.svh"

module tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        hwrite;
  logic        hready;
  logic        split;
  logic        avalid;
  logic        awrite;
  logic        irq_en;
  logic        tog;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] aaddr;
  logic [31:0] adata;
  logic [31:0] pc;
  logic [31:0] rd;
  logic [5:0]  evt;
  logic [2:0]  outs;
  logic        hresp;
  logic        irq;
  logic        abrt;
  logic        vev;
  logic        frz;
  logic [31:0] hrdata;
  int          n_fail;
  int          n_tests;
  // Status image with the reset-cause strap of 2 in bits 13:12
  localparam logic [31:0] CAUSE_IMG = 32'h0000_2000;

  dbe_events dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(`DBE_HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .access_valid_i(avalid), .access_write_i(awrite), .access_split_i(split),
    .access_addr_i(aaddr), .access_data_i(adata), .next_pc_i(pc),
    .instr_complete_event_i(evt[0]), .branch_taken_event_i(evt[1]),
    .exception_taken_event_i(evt[2]), .trap_event_i(evt[3]),
    .unconditional_event_i(evt[4]), .instr_addr_compare_i(evt[5]),
    .range_toggle_en_i(tog), .debug_irq_enable_i(irq_en), .last_reset_cause_i(2'h2),
    .debug_irq_o(irq), .abort_second_o(abrt), .value_event_o(vev), .timers_frozen_o(frz)
  );

  // Clock of 25 ns
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Bounded wait for hready sampled high
  task automatic wrdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      n_fail++;
      final_report;
    end
  endtask

  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wrdy;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy;
    rd = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // One data access, outputs taken in the following cycle
  task automatic acc(input logic w, input logic s, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] p);
    avalid <= 1'b1;
    awrite <= w;
    split  <= s;
    aaddr  <= a;
    adata  <= d;
    pc     <= p;
    @(posedge clk_i);
    avalid <= 1'b0;
    split  <= 1'b0;
    @(posedge clk_i);
    outs = {irq, abrt, vev};
  endtask

  task automatic ev(input int i);
    evt <= 6'h01 << i;
    @(posedge clk_i);
    evt <= 6'h00;
    @(posedge clk_i);
  endtask

  task automatic t_reset;
    rdc(`DBE_OFS_CTL1, 32'h0);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG);
    rdc(8'h40, 32'h0);
    bus(1'b1, `DBE_OFS_SAVE, 32'hFFFF_FFFF);
    rdc(`DBE_OFS_SAVE, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask

  // Byte enables and compare modes; mode 00 is never programmed
  task automatic t_modes;
    logic [3:0]  bes [4];
    logic [0:11] ex;
    bes = '{4'b1110, 4'b0001, 4'b0011, 4'b1111}; // Field bit i enables byte i, byte 0 on top
    ex  = 12'b010110111011;
    bus(1'b1, `DBE_OFS_ADDR1, 32'h100);
    bus(1'b1, `DBE_OFS_VAL1, 32'hABCD_0123);
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, `DBE_OFS_CTL1, (32'(i % 3 + 1) << 16) | (32'(bes[i / 3]) << 8) | 32'h1);
      acc(1'b0, 1'b0, 32'h100, 32'hABCD_FFFF, 32'h0);
      chk({31'h0, outs[0]}, {31'h0, ex[i]});
      rdc(`DBE_OFS_STATUS, ex[i] ? (CAUSE_IMG | 32'h11) : CAUSE_IMG);
      chk({31'h0, frz}, 32'h0);
      bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    end
    $display("test modes done");
  endtask

  task automatic t_rw;
    bus(1'b1, `DBE_OFS_ADDR2, 32'h200);
    bus(1'b1, `DBE_OFS_VAL2, 32'h1234_5678);
    bus(1'b1, `DBE_OFS_CTL1, 32'h0004_F008);
    acc(1'b1, 1'b0, 32'h200, 32'h1234_5678, 32'h0);
    chk({29'h0, outs}, 32'h1);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG | 32'h18);
    bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    acc(1'b0, 1'b0, 32'h200, 32'h1234_5678, 32'h0);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG);
    acc(1'b1, 1'b0, 32'h200, 32'h1234_5600, 32'h0);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG);
    // Value compare off on comparator 1: plain address write hit is recorded
    bus(1'b1, `DBE_OFS_CTL1, 32'h0000_0002);
    acc(1'b1, 1'b0, 32'h100, 32'h0, 32'h0);
    chk({29'h0, outs}, 32'h0);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG | 32'h12);
    bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    $display("test read write done");
  endtask

  task automatic t_irq;
    bus(1'b1, `DBE_OFS_CTL0, 32'h1);
    bus(1'b1, `DBE_OFS_CTL1, 32'h0001_0F01);
    irq_en <= 1'b1;
    acc(1'b0, 1'b1, 32'h100, 32'hABCD_0123, 32'h1000);
    chk({29'h0, outs}, 32'h7);
    rdc(`DBE_OFS_SAVE, 32'h1000);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG | 32'h1);
    bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    irq_en <= 1'b0;
    acc(1'b0, 1'b0, 32'h100, 32'hABCD_0123, 32'h0);
    chk({29'h0, outs}, 32'h1);
    rdc(`DBE_OFS_STATUS, CAUSE_IMG | 32'h11);
    irq_en <= 1'b1;
    pc     <= 32'h2000;
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    rdc(`DBE_OFS_SAVE, 32'h2000);
    // Re-enabling with the flag still set interrupts again
    irq_en <= 1'b0;
    @(posedge clk_i);
    irq_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    irq_en <= 1'b0;
    @(posedge clk_i);
    irq_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    irq_en <= 1'b0;
    $display("test interrupt done");
  endtask

  // Entries: event index, internal mode, toggling, expected status
  task automatic t_imp;
    logic [15:0] tb [9];
    tb = '{{3'd0, 2'b00, 11'h030}, {3'd0, 2'b10, 11'h020}, {3'd1, 2'b00, 11'h050},
           {3'd1, 2'b10, 11'h040}, {3'd2, 2'b10, 11'h090}, {3'd3, 2'b10, 11'h110},
           {3'd4, 2'b10, 11'h210}, {3'd5, 2'b11, 11'h400}, {3'd5, 2'b10, 11'h410}};
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, `DBE_OFS_CTL0, {31'h0, tb[i][12]});
      tog <= tb[i][11];
      ev(int'(tb[i][15:13]));
      rdc(`DBE_OFS_STATUS, CAUSE_IMG | {21'h0, tb[i][10:0]});
      bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    end
    tog <= 1'b0;
    $display("test imprecise done");
  endtask

  task automatic t_freeze;
    bus(1'b1, `DBE_OFS_CTL0, 32'h2);
    ev(3);
    chk({31'h0, frz}, 32'h1);
    bus(1'b1, `DBE_OFS_STATUS, 32'h10);
    repeat (2) @(posedge clk_i);
    chk({31'h0, frz}, 32'h1);
    bus(1'b1, `DBE_OFS_STATUS, 32'h100);
    repeat (2) @(posedge clk_i);
    chk({31'h0, frz}, 32'h0);
    bus(1'b1, `DBE_OFS_CTL0, 32'h0);
    $display("test freeze done");
  endtask

  task automatic t_range;
    logic [31:0] ad [6];
    logic [0:5]  ex;
    ad = '{32'h100, 32'h1FF, 32'h200, 32'h0FF, 32'h200, 32'h100};
    ex = 6'b110010;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `DBE_OFS_CTL1, (i > 3) ? 32'h0001_0F31 : 32'h0001_0F11);
      acc(1'b0, 1'b0, ad[i], 32'hABCD_0123, 32'h0);
      chk({31'h0, outs[0]}, {31'h0, ex[i]});
      bus(1'b1, `DBE_OFS_STATUS, 32'h7FF);
    end
    $display("test range done");
  endtask

  // Main sequence
  initial begin
    {rst_i, hwrite, split, avalid, awrite, irq_en, tog} = 7'h40;
    {htrans, haddr, hwdata, aaddr, adata, pc, evt} = '0;
    n_fail  = 0;
    n_tests = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_modes;
    t_rw;
    t_irq;
    t_imp;
    t_freeze;
    t_range;
    final_report;
  end
endmodule // tb_top
